//--- common/iorsd_defines.svh
// constants for the low i/o register space decoder
`ifndef IORSD_DEFINES_SVH
`define IORSD_DEFINES_SVH
// ----------------------------------------
// address windows
// ----------------------------------------
`define IORSD_IO_LAST 6'h3F
`define IORSD_BIT_LAST 6'h1F
`define IORSD_DS_OFFSET 8'h20
`define IORSD_DS_IO_LAST 8'h5F
`define IORSD_EXT_FIRST 8'h60
// ----------------------------------------
// register i/o addresses
// ----------------------------------------
`define IORSD_A_PB_PIN 6'h03
`define IORSD_A_PB_DIR 6'h04
`define IORSD_A_PB_OUT 6'h05
`define IORSD_A_PC_PIN 6'h06
`define IORSD_A_PC_DIR 6'h07
`define IORSD_A_PC_OUT 6'h08
`define IORSD_A_PD_PIN 6'h09
`define IORSD_A_PD_DIR 6'h0A
`define IORSD_A_PD_OUT 6'h0B
`define IORSD_A_T0_FLG 6'h15
`define IORSD_A_T1_FLG 6'h16
`define IORSD_A_T2_FLG 6'h17
`define IORSD_A_EXT_FLG 6'h1C
`define IORSD_A_EXT_MSK 6'h1D
`define IORSD_A_SCR0 6'h1E
`define IORSD_A_EECTL 6'h1F
`define IORSD_A_EEDAT 6'h20
`define IORSD_A_EEAL 6'h21
`define IORSD_A_EEAH 6'h22
`define IORSD_A_PRESC 6'h23
`define IORSD_A_T0CA 6'h24
`define IORSD_A_T0CB 6'h25
`define IORSD_A_T0CNT 6'h26
`define IORSD_A_T0OCA 6'h27
`define IORSD_A_T0OCB 6'h28
`define IORSD_A_SCR1 6'h2A
// ----------------------------------------
// implemented-bit masks and reset values
// ----------------------------------------
`define IORSD_M_ALL 8'hFF
`define IORSD_M_PC 8'h7F
`define IORSD_M_T0FLG 8'h07
`define IORSD_M_T1FLG 8'h27
`define IORSD_M_T2FLG 8'h07
`define IORSD_M_EXT 8'h03
`define IORSD_M_PRESC 8'h83
`define IORSD_M_T0CA 8'hF3
`define IORSD_M_T0CB 8'h0F
`define IORSD_M_T0CB_STROBE 8'hC0
`define IORSD_M_EECTL 8'h3F
`define IORSD_RST 8'h00
`define IORSD_NREG 26
`endif

//--- common/iorsd_pkg.sv
// types for the low i/o register space decoder
package iorsd_pkg;
   typedef enum logic [2:0] {
      IORSD_OP_NONE,
      IORSD_OP_IO_RD,
      IORSD_OP_IO_WR,
      IORSD_OP_DS_RD,
      IORSD_OP_DS_WR,
      IORSD_OP_BIT_SET,
      IORSD_OP_BIT_CLR,
      IORSD_OP_BIT_TST
   } iorsd_op_t;

   typedef struct packed {
      iorsd_op_t op;
      logic [7:0] addr;
      logic [2:0] bit_idx;
      logic [7:0] wdata;
   } iorsd_req_t;

   typedef struct packed {
      logic valid;
      logic [7:0] rdata;
      logic bit_val;
      logic hit;
   } iorsd_rsp_t;

   typedef struct packed {
      logic [7:0] t0;
      logic [7:0] t1;
      logic [7:0] t2;
      logic [7:0] ext;
   } iorsd_evt_t;
endpackage : iorsd_pkg

//--- verilog/iorsd_decode.sv
// address decoder: turns a request into an i/o register index
`timescale 1ns/1ns
`include "iorsd_defines.svh"
module iorsd_decode
   import iorsd_pkg::*;
(
   input wire iorsd_pkg::iorsd_req_t req,
   output logic io_ok,
   output logic [5:0] io_addr,
   output logic is_wr,
   output logic is_rd,
   output logic is_bit
);
   import iorsd_pkg::*;
   always_comb begin
      io_ok = 1'b0;
      io_addr = req.addr[5:0];
      is_wr = 1'b0;
      is_rd = 1'b0;
      is_bit = 1'b0;
      case (req.op)
         IORSD_OP_IO_RD, IORSD_OP_IO_WR: begin
            // io opcodes carry 6 address bits; the upper two are ignored
            io_ok = 1'b1;
            is_wr = (req.op == IORSD_OP_IO_WR);
            is_rd = !is_wr;
         end
         IORSD_OP_DS_RD, IORSD_OP_DS_WR: begin
            // extended region above 0x5F is not ours; io ops never reach it
            io_ok = (req.addr >= `IORSD_DS_OFFSET) && (req.addr <= `IORSD_DS_IO_LAST);
            io_addr = 6'(req.addr - `IORSD_DS_OFFSET);
            is_wr = (req.op == IORSD_OP_DS_WR);
            is_rd = !is_wr;
         end
         IORSD_OP_BIT_SET, IORSD_OP_BIT_CLR, IORSD_OP_BIT_TST: begin
            io_ok = (req.addr[5:0] <= `IORSD_BIT_LAST);
            is_bit = 1'b1;
         end
         default: begin
            io_ok = 1'b0;
         end
      endcase
   end
endmodule : iorsd_decode

//--- verilog/iorsd_bank.sv
// low i/o register bank with io, data-space and single-bit access
// Contract
// - registers 0x00 to 0x1F accept single-bit set and clear.
// - registers 0x00 to 0x1F allow testing one bit for a skip.
// - status flags clear on a written one; a written zero keeps them.
// - bit set or clear touches only the named bit, sparing other flags.
// - io read and write use addresses 0x00 to 0x3F.
// - data-space access maps each register at its io address plus 0x20.
// - extended region 0x60 to 0xFF is not reachable by io instructions.
`timescale 1ns/1ns
`include "iorsd_defines.svh"
module iorsd_bank
   import iorsd_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire iorsd_pkg::iorsd_req_t req,
   output iorsd_pkg::iorsd_rsp_t rsp,
   input wire logic [7:0] pin_b,
   input wire logic [7:0] pin_c,
   input wire logic [7:0] pin_d,
   input wire iorsd_pkg::iorsd_evt_t evt_set,
   output logic [7:0] port_b_out,
   output logic [7:0] port_b_dir,
   output logic [7:0] port_c_out,
   output logic [7:0] port_c_dir,
   output logic [7:0] port_d_out,
   output logic [7:0] port_d_dir,
   output logic [7:0] ext_irq_mask_out,
   output iorsd_pkg::iorsd_evt_t flags_out,
   output logic [7:0] t0_strobe
);
   import iorsd_pkg::*;

   // ----------------------------------------
   // state
   // ----------------------------------------
   typedef struct packed {
      logic [`IORSD_NREG-1:0][7:0] regs;
      iorsd_rsp_t rsp;
      logic [7:0] strobe;
   } iorsd_state_t;

   iorsd_state_t st_q;
   iorsd_state_t st_d;
   logic io_ok;
   logic [5:0] io_addr;
   logic is_wr;
   logic is_rd;
   logic is_bit;

   iorsd_decode u_dec (
      .req(req),
      .io_ok(io_ok),
      .io_addr(io_addr),
      .is_wr(is_wr),
      .is_rd(is_rd),
      .is_bit(is_bit)
   );

   // ----------------------------------------
   // address table: io address, slot, writable mask, w1c
   // ----------------------------------------
   localparam logic [`IORSD_NREG-1:0][5:0] ADDR_TAB = {
      `IORSD_A_SCR1, `IORSD_A_T0OCB, `IORSD_A_T0OCA, `IORSD_A_T0CNT,
      `IORSD_A_T0CB, `IORSD_A_T0CA, `IORSD_A_PRESC, `IORSD_A_EEAH,
      `IORSD_A_EEAL, `IORSD_A_EEDAT, `IORSD_A_EECTL, `IORSD_A_SCR0,
      `IORSD_A_EXT_MSK, `IORSD_A_EXT_FLG, `IORSD_A_T2_FLG, `IORSD_A_T1_FLG,
      `IORSD_A_T0_FLG, `IORSD_A_PD_OUT, `IORSD_A_PD_DIR, `IORSD_A_PD_PIN,
      `IORSD_A_PC_OUT, `IORSD_A_PC_DIR, `IORSD_A_PC_PIN, `IORSD_A_PB_OUT,
      `IORSD_A_PB_DIR, `IORSD_A_PB_PIN};
   localparam logic [`IORSD_NREG-1:0][7:0] MASK_TAB = {
      `IORSD_M_ALL, `IORSD_M_ALL, `IORSD_M_ALL, `IORSD_M_ALL,
      `IORSD_M_T0CB, `IORSD_M_T0CA, `IORSD_M_PRESC, `IORSD_M_ALL,
      `IORSD_M_ALL, `IORSD_M_ALL, `IORSD_M_EECTL, `IORSD_M_ALL,
      `IORSD_M_EXT, `IORSD_M_EXT, `IORSD_M_T2FLG, `IORSD_M_T1FLG,
      `IORSD_M_T0FLG, `IORSD_M_ALL, `IORSD_M_ALL, `IORSD_M_ALL,
      `IORSD_M_PC, `IORSD_M_PC, `IORSD_M_PC, `IORSD_M_ALL,
      `IORSD_M_ALL, `IORSD_M_ALL};
   localparam int SLOT_PB_PIN = 0;
   localparam int SLOT_PB_DIR = 1;
   localparam int SLOT_PB_OUT = 2;
   localparam int SLOT_PC_PIN = 3;
   localparam int SLOT_PC_DIR = 4;
   localparam int SLOT_PC_OUT = 5;
   localparam int SLOT_PD_PIN = 6;
   localparam int SLOT_PD_DIR = 7;
   localparam int SLOT_PD_OUT = 8;
   localparam int SLOT_T0F = 9;
   localparam int SLOT_T1F = 10;
   localparam int SLOT_T2F = 11;
   localparam int SLOT_EXTF = 12;
   localparam int SLOT_EXTM = 13;
   localparam int SLOT_T0CB = 21;

   function automatic logic is_w1c(input int s);
      return (s >= SLOT_T0F) && (s <= SLOT_EXTF);
   endfunction : is_w1c

   function automatic logic is_ro(input int s);
      return (s == SLOT_PB_PIN) || (s == SLOT_PC_PIN) || (s == SLOT_PD_PIN);
   endfunction : is_ro

   // one-hot match of an io address against the table
   logic [`IORSD_NREG-1:0] hit_vec;
   genvar g;
   generate
      for (g = 0; g < `IORSD_NREG; g++) begin : g_hit
         assign hit_vec[g] = io_ok && (io_addr == ADDR_TAB[g]);
      end
   endgenerate

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb begin
      logic [7:0] cur;
      logic [7:0] bmask;
      logic [7:0] nv;
      logic [7:0] evt;
      cur = `IORSD_RST;
      bmask = 8'(1) << req.bit_idx;
      nv = `IORSD_RST;
      evt = `IORSD_RST;
      st_d = st_q;
      st_d.rsp = '0;
      st_d.strobe = `IORSD_RST;
      st_d.rsp.valid = (req.op != IORSD_OP_NONE);
      // pins are sampled every cycle
      st_d.regs[SLOT_PB_PIN] = pin_b;
      st_d.regs[SLOT_PC_PIN] = pin_c & `IORSD_M_PC;
      st_d.regs[SLOT_PD_PIN] = pin_d;
      for (int s = 0; s < `IORSD_NREG; s++) begin
         cur = st_q.regs[s];
         if (hit_vec[s]) begin
            st_d.rsp.hit = 1'b1;
            if (is_rd) begin
               st_d.rsp.rdata = cur & MASK_TAB[s];
            end
            if (is_bit) begin
               st_d.rsp.bit_val = cur[req.bit_idx] & MASK_TAB[s][req.bit_idx];
            end
            if (!is_ro(s)) begin
               nv = cur;
               if (is_wr && is_w1c(s)) begin
                  nv = cur & ~(req.wdata & MASK_TAB[s]);
               end else if (is_wr) begin
                  nv = req.wdata & MASK_TAB[s];
               end else if (req.op == IORSD_OP_BIT_SET && is_w1c(s)) begin
                  nv = cur & ~(bmask & MASK_TAB[s]);
               end else if (req.op == IORSD_OP_BIT_SET) begin
                  nv = cur | (bmask & MASK_TAB[s]);
               end else if (req.op == IORSD_OP_BIT_CLR && !is_w1c(s)) begin
                  nv = cur & ~bmask;
               end
               if ((s == SLOT_T0CB) && is_wr) begin
                  // force bits are strobes: taken from the written byte, never stored
                  st_d.strobe = req.wdata & `IORSD_M_T0CB_STROBE;
               end
               st_d.regs[s] = nv;
            end
         end
      end
      // hardware events win over a same-cycle clear
      for (int f = 0; f < 4; f++) begin
         case (f)
            0: evt = evt_set.t0;
            1: evt = evt_set.t1;
            2: evt = evt_set.t2;
            default: evt = evt_set.ext;
         endcase
         st_d.regs[SLOT_T0F + f] =
            st_d.regs[SLOT_T0F + f] | (evt & MASK_TAB[SLOT_T0F + f]);
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   assign rsp = st_q.rsp;
   assign port_b_out = st_q.regs[SLOT_PB_OUT];
   assign port_b_dir = st_q.regs[SLOT_PB_DIR];
   assign port_c_out = st_q.regs[SLOT_PC_OUT];
   assign port_c_dir = st_q.regs[SLOT_PC_DIR];
   assign port_d_out = st_q.regs[SLOT_PD_OUT];
   assign port_d_dir = st_q.regs[SLOT_PD_DIR];
   assign ext_irq_mask_out = st_q.regs[SLOT_EXTM];
   assign flags_out.t0 = st_q.regs[SLOT_T0F];
   assign flags_out.t1 = st_q.regs[SLOT_T1F];
   assign flags_out.t2 = st_q.regs[SLOT_T2F];
   assign flags_out.ext = st_q.regs[SLOT_EXTF];
   assign t0_strobe = st_q.strobe;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);

   bit_set_only_a: assert property (
      (req.op == IORSD_OP_BIT_SET) && hit_vec[SLOT_PB_OUT]
      |=> ((port_b_out ^ $past(port_b_out)) & ~(8'(1) << $past(req.bit_idx))) == 8'h00)
      else $error("bit set touched other bits");
   bit_clr_eff_a: assert property (
      (req.op == IORSD_OP_BIT_CLR) && hit_vec[SLOT_PB_OUT]
      |=> port_b_out[$past(req.bit_idx)] == 1'b0)
      else $error("bit clear failed");
   w1c_one_a: assert property (
      is_wr && hit_vec[SLOT_T0F] && req.wdata[0] && !evt_set.t0[0]
      |=> flags_out.t0[0] == 1'b0)
      else $error("flag not cleared by one");
   w1c_zero_a: assert property (
      is_wr && hit_vec[SLOT_T0F] && !req.wdata[0] && flags_out.t0[0]
      |=> flags_out.t0[0])
      else $error("flag lost on zero write");
   ds_map_a: assert property (
      (req.op == IORSD_OP_DS_WR) && (req.addr == (`IORSD_DS_OFFSET + 8'h05))
      |=> port_b_out == $past(req.wdata))
      else $error("data space offset wrong");
   io_map_a: assert property (
      (req.op == IORSD_OP_IO_WR) && (req.addr == 8'h05)
      |=> port_b_out == $past(req.wdata))
      else $error("io write missed");
   ext_region_a: assert property (
      (req.op == IORSD_OP_DS_RD) && (req.addr >= `IORSD_EXT_FIRST) |=> !rsp.hit)
      else $error("extended region decoded");
   unused_zero_a: assert property (
      (req.op == IORSD_OP_IO_RD) && (req.addr == 8'h10) |=> rsp.rdata == 8'h00)
      else $error("unused address not zero");
   bit_range_a: assert property (
      is_bit && (req.addr[5:0] > `IORSD_BIT_LAST) |=> !rsp.hit && !rsp.bit_val)
      else $error("bit op above range");
   set_wins_a: assert property (
      evt_set.ext[0] |=> flags_out.ext[0])
      else $error("event lost");

   c_bit_set: cover property ((req.op == IORSD_OP_BIT_SET) ##1 rsp.hit);
   c_w1c: cover property (is_wr && hit_vec[SLOT_EXTF] ##1 rsp.valid);
   c_ds_rd: cover property ((req.op == IORSD_OP_DS_RD) ##1 rsp.hit);
   c_tst: cover property ((req.op == IORSD_OP_BIT_TST) ##1 rsp.bit_val);
endmodule : iorsd_bank

//--- verif/iorsd_core_model.sv
// processor core model issuing i/o, data-space and bit requests
`timescale 1ns/1ns
module iorsd_core_model
   import iorsd_pkg::*;
(
   input wire logic clk_sys,
   output iorsd_pkg::iorsd_req_t req,
   input wire iorsd_pkg::iorsd_rsp_t rsp
);
   initial begin
      req = '0;
   end
   // the request stays up after the answer, so calls made one after another
   // give true back-to-back traffic; idle drops it for one cycle
   task automatic xfer(input iorsd_op_t op, input logic [7:0] ad, input logic [2:0] bi,
      input logic [7:0] wd, output iorsd_rsp_t rr);
      req = '{op: op, addr: ad, bit_idx: bi, wdata: wd};
      @(negedge clk_sys);
      rr = rsp;
   endtask : xfer
   task automatic idle();
      req = '0;
      @(negedge clk_sys);
   endtask : idle
endmodule : iorsd_core_model

//--- verif/iorsd_bank_test.sv
// self-checking bench for the low i/o register bank
`timescale 1ns/1ns
module iorsd_bank_test;
   import iorsd_pkg::*;
   logic clk_sys, rst_n;
   logic [7:0] pin_b, pin_c, pin_d, port_b_out, port_b_dir, port_c_out, port_c_dir;
   logic [7:0] port_d_out, port_d_dir, ext_irq_mask_out, t0_strobe, d, e;
   logic [5:0] a;
   logic [2:0] b;
   iorsd_req_t req;
   iorsd_rsp_t rsp, r;
   iorsd_evt_t evt_set, flags_out;
   logic [7:0] m [64];
   int mismatches, n_compared;
   // written registers; the first eight sit in the bit-accessible range
   logic [5:0] rw_list [16] = '{6'h04, 6'h05, 6'h07, 6'h08, 6'h0A, 6'h0B, 6'h1D, 6'h1E,
      6'h20, 6'h21, 6'h24, 6'h25, 6'h26, 6'h27, 6'h28, 6'h2A};
   logic [5:0] flg [4] = '{6'h15, 6'h16, 6'h17, 6'h1C};

   iorsd_bank i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .req(req), .rsp(rsp),
      .pin_b(pin_b), .pin_c(pin_c), .pin_d(pin_d), .evt_set(evt_set),
      .port_b_out(port_b_out), .port_b_dir(port_b_dir), .port_c_out(port_c_out),
      .port_c_dir(port_c_dir), .port_d_out(port_d_out), .port_d_dir(port_d_dir),
      .ext_irq_mask_out(ext_irq_mask_out), .flags_out(flags_out), .t0_strobe(t0_strobe));
   iorsd_core_model core (.clk_sys(clk_sys), .req(req), .rsp(rsp));

   // ----------------------------------------
   // expectation helpers
   // ----------------------------------------
   function automatic logic [7:0] msk(input logic [5:0] ad);
      case (ad)
         6'h06, 6'h07, 6'h08: return 8'h7F;
         6'h15, 6'h17: return 8'h07;
         6'h16: return 8'h27;
         6'h1C, 6'h1D: return 8'h03;
         6'h24: return 8'hF3;
         6'h25: return 8'h0F;
         default: return 8'hFF;
      endcase
   endfunction : msk
   task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic go(input iorsd_op_t op, input logic [7:0] ad, input logic [2:0] bi,
      input logic [7:0] wd);
      core.xfer(op, ad, bi, wd, r);
      chk("valid", {7'h00, r.valid}, 8'h01);
   endtask : go
   task automatic rd(input iorsd_op_t op, input logic [7:0] ad, input logic [7:0] ex);
      go(op, ad, 3'h0, 8'h00);
      chk("rdata", r.rdata, ex);
   endtask : rd
   task automatic wrap_up();
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : wrap_up

   // ----------------------------------------
   // clock, watchdog and sequence
   // ----------------------------------------
   initial begin
      clk_sys = 1'b0;
      forever #2 clk_sys = ~clk_sys;
   end
   initial begin
      repeat (100000) @(posedge clk_sys);
      mismatches++;
      wrap_up();
   end
   initial begin
      rst_n = 1'b0;
      {pin_b, pin_c, pin_d} = 24'h000000;
      evt_set = '0;
      m = '{default: 8'h00};
      void'($urandom(32'hE3BD19EE));
      repeat (8) @(negedge clk_sys);
      rst_n = 1'b1;
      for (int i = 0; i < 64; i++) rd(IORSD_OP_IO_RD, 8'(i), 8'h00);
      $display("test reset_scan done");
      repeat (150) begin
         a = rw_list[$urandom_range(15)];
         d = 8'($urandom) & msk(a);
         if ($urandom_range(1) == 1) go(IORSD_OP_IO_WR, {2'($urandom), a}, 3'h0, d);
         else go(IORSD_OP_DS_WR, {2'b00, a} + 8'h20, 3'h0, d);
         m[a] = d;
         a = rw_list[$urandom_range(15)];
         if ($urandom_range(1) == 1) rd(IORSD_OP_IO_RD, {2'($urandom), a}, m[a]);
         else rd(IORSD_OP_DS_RD, {2'b00, a} + 8'h20, m[a]);
      end
      $display("test random_rw done");
      repeat (150) begin
         a = rw_list[$urandom_range(7)];
         b = 3'($urandom);
         if ($urandom_range(1) == 1) begin
            go(IORSD_OP_BIT_SET, {2'b00, a}, b, 8'h00);
            m[a] = m[a] | ((8'h01 << b) & msk(a));
         end else begin
            go(IORSD_OP_BIT_CLR, {2'b00, a}, b, 8'h00);
            m[a] = m[a] & ~(8'h01 << b);
         end
         b = 3'($urandom);
         go(IORSD_OP_BIT_TST, {2'b00, a}, b, 8'h00);
         chk("bit_val", {7'h00, r.bit_val}, {7'h00, m[a][b]});
         rd(IORSD_OP_IO_RD, {2'b00, a}, m[a]);
      end
      go(IORSD_OP_BIT_SET, 8'h25, 3'h2, 8'h00);
      chk("high_bit_hit", {7'h00, r.hit}, 8'h00);
      rd(IORSD_OP_IO_RD, 8'h25, m[6'h25]);
      $display("test bit_ops done");
      for (int i = 0; i < 12; i++) begin
         a = flg[i % 4];
         e = 8'($urandom);
         evt_set = iorsd_evt_t'({24'h000000, e} << (8 * (3 - (i % 4))));
         core.idle();
         evt_set = '0;
         m[a] = m[a] | (e & msk(a));
         rd(IORSD_OP_IO_RD, {2'b00, a}, m[a]);
         d = 8'($urandom) & msk(a);
         go(IORSD_OP_IO_WR, {2'b00, a}, 3'h0, d);
         m[a] = m[a] & ~d;
         rd(IORSD_OP_DS_RD, {2'b00, a} + 8'h20, m[a]);
         b = 3'($urandom);
         go(IORSD_OP_BIT_SET, {2'b00, a}, b, 8'h00);
         m[a] = m[a] & ~(8'h01 << b);
         go(IORSD_OP_BIT_CLR, {2'b00, a}, b ^ 3'h1, 8'h00);
         rd(IORSD_OP_IO_RD, {2'b00, a}, m[a]);
         chk("flags_out", flags_out[31 - 8 * (i % 4) -: 8], m[a]);
      end
      // event and clearing write in the same cycle: the event must win
      evt_set = iorsd_evt_t'(32'h0100_0000);
      go(IORSD_OP_IO_WR, 8'h15, 3'h0, 8'h07);
      evt_set = '0;
      m[6'h15] = 8'h01;
      rd(IORSD_OP_IO_RD, 8'h15, m[6'h15]);
      $display("test flags done");
      {pin_b, pin_c, pin_d} = 24'($urandom);
      core.idle();
      core.idle();
      rd(IORSD_OP_IO_RD, 8'h03, pin_b);
      chk("pin_hit", {7'h00, r.hit}, 8'h01);
      rd(IORSD_OP_DS_RD, 8'h26, pin_c & 8'h7F);
      rd(IORSD_OP_IO_RD, 8'h09, pin_d);
      rd(IORSD_OP_DS_RD, 8'h30, 8'h00);
      rd(IORSD_OP_DS_RD, 8'h10, 8'h00);
      chk("low_ds_hit", {7'h00, r.hit}, 8'h00);
      go(IORSD_OP_DS_WR, 8'h66, 3'h0, ~m[6'h05]);
      chk("ext_hit", {7'h00, r.hit}, 8'h00);
      rd(IORSD_OP_IO_RD, 8'h05, m[6'h05]);
      rd(IORSD_OP_DS_RD, 8'h60, 8'h00);
      chk("ext_rd_hit", {7'h00, r.hit}, 8'h00);
      $display("test pins_and_windows done");
      go(IORSD_OP_IO_WR, 8'h25, 3'h0, 8'hC0 | m[6'h25]);
      chk("t0_strobe", t0_strobe, 8'hC0);
      core.idle();
      chk("t0_strobe_end", t0_strobe, 8'h00);
      rd(IORSD_OP_IO_RD, 8'h25, m[6'h25]);
      chk("port_b_dir", port_b_dir, m[6'h04]);
      chk("port_b_out", port_b_out, m[6'h05]);
      chk("port_c_dir", port_c_dir, m[6'h07]);
      chk("port_c_out", port_c_out, m[6'h08]);
      chk("port_d_dir", port_d_dir, m[6'h0A]);
      chk("port_d_out", port_d_out, m[6'h0B]);
      chk("irq_mask", ext_irq_mask_out, m[6'h1D]);
      $display("test outputs done");
      wrap_up();
   end
endmodule : iorsd_bank_test
